//--- hdl/ftdm_regs.svh
// register indices, field positions, reset values and timing for the fan duty mapper
// assumes byte address = 4 * index on a 32-bit apb bus
`ifndef FTDM_REGS_SVH
`define FTDM_REGS_SVH

`define FTDM_IDX_F1_SEGA 8'hAB
`define FTDM_IDX_F1_SEGB 8'hAE
`define FTDM_IDX_F1_CTRL 8'hAF
`define FTDM_IDX_CNT_HI 8'hB0
`define FTDM_IDX_CNT_LO 8'hB1
`define FTDM_IDX_SPARE 8'hB2
`define FTDM_IDX_DUTY 8'hB3
`define FTDM_IDX_FULL_HI 8'hB4
`define FTDM_IDX_FULL_LO 8'hB5
`define FTDM_IDX_BOUND1 8'hB6
`define FTDM_IDX_HYST 8'hB7
`define FTDM_IDX_MODE 8'hB8
`define FTDM_IDX_BOUND2 8'hB9
`define FTDM_IDX_F2_SEGA 8'hBB
`define FTDM_IDX_F2_SEGB 8'hBE

`define FTDM_BIT_FORCE 5
`define FTDM_BIT_INTERP 4
`define FTDM_BIT_JUMP_UP 3
`define FTDM_BIT_JUMP_DN 2
`define FTDM_BIT_AUTO 0

`define FTDM_RST_SEGA 8'hD9
`define FTDM_RST_SEGB 8'h80
`define FTDM_RST_CTRL 6'h0D
`define FTDM_RST_CNT 16'h0FFF
`define FTDM_RST_SPARE 8'h00
`define FTDM_RST_DUTY 8'h01
`define FTDM_RST_FULL_HI 8'h03
`define FTDM_RST_FULL_LO 8'hFF
`define FTDM_RST_BOUND1 7'h42
`define FTDM_RST_BOUND2 7'h1E
`define FTDM_RST_HYST 7'h04
`define FTDM_RST_AUTO 1'b1

`define FTDM_DUTY_FULL 8'hFF
`define FTDM_CLK_HZ 125000000
`define FTDM_SLOPE_HZ 5
`define FTDM_SLOPE_CYCLES (`FTDM_CLK_HZ / `FTDM_SLOPE_HZ)

`endif

//--- hdl/ftdm_pkg.sv
// types for the fan duty mapper
// assumes nothing beyond the register header
package ftdm_pkg;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [9:0] paddr;
      logic [31:0] pwdata;
   } ftdm_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } ftdm_apb_rsp_t;

   typedef struct packed {
      logic [7:0] t1;
      logic [7:0] t2;
      logic [7:0] t3;
   } ftdm_temps_t;

   typedef enum logic [2:0] {
      SEC_FULL = 3'b001,
      SEC_A = 3'b010,
      SEC_B = 3'b100
   } ftdm_sec_t;
endpackage

//--- hdl/ftdm_mapper.sv
// fan temperature to duty mapper with apb register slave
// assumes temps, over-temp flag and tach count come from logic on mclk
//
// Operation
// - each fan has two 8-bit segment duty registers, segment A resets D9h, B 80h
// - force bit set and any over-temperature: drive full duty
// - interpolate bit set: duty interpolates between segment values across the band
// - rising past top boundary: jump to full if jump-up set, else ramp
// - falling below top minus hysteresis: jump to segment A if set, else ramp
// - two-bit select picks temperature 1..3; zero is reserved; resets to 1
// - count MSB read latches count LSB for the following LSB read
// - duty register is value/255, reset 01h, hardware-updated in auto mode
// - writable full-speed count pair resets 03FFh with same MSB latch
// - above boundary 1 the expected duty is FFh
// - below boundary 1 minus hysteresis the expected duty is segment A
// - above boundary 2 segment A, below boundary 2 minus hysteresis segment B
//
// Implementation choice: the APB register port.
`include "ftdm_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module ftdm_mapper #(
   parameter int unsigned SLOPE_CYCLES = `FTDM_SLOPE_CYCLES
) (
   input wire logic mclk,
   input wire logic nrst,
   input wire ftdm_pkg::ftdm_apb_req_t apbReq,
   output ftdm_pkg::ftdm_apb_rsp_t apbRsp,
   input wire ftdm_pkg::ftdm_temps_t temps,
   input wire logic overTemp,
   input wire logic [15:0] tachCount,
   input wire logic tachValid,
   output logic [7:0] fanDuty,
   output logic [2:0] section
);

   // refuse slope counts the 25-bit timebase cannot hold
   if (SLOPE_CYCLES < 1 || SLOPE_CYCLES >= (1 << 25))
   begin : slopeRangeChk
      $error("SLOPE_CYCLES out of range");
   end

   function automatic logic [7:0] lowEdge(input logic [6:0] b, input logic [6:0] h);
      lowEdge = (b > h) ? {1'b0, b - h} : 8'h00;
   endfunction

   function automatic logic [7:0] interp(input logic [7:0] lo, input logic [7:0] hi,
                                         input logic [7:0] num, input logic [7:0] den);
      logic [15:0] span;
      logic [7:0] n;
      span = 16'h0000;
      n = (num > den) ? den : num;
      if (den == 8'h00)
      begin
         interp = hi;
      end
      else if (hi >= lo)
      begin
         span = ({8'h00, hi - lo} * {8'h00, n}) / {8'h00, den};
         interp = lo + span[7:0];
      end
      else
      begin
         span = ({8'h00, lo - hi} * {8'h00, n}) / {8'h00, den};
         interp = lo - span[7:0];
      end
   endfunction

   logic [7:0] f1SegA_r, f1SegB_r, f2SegA_r, f2SegB_r;
   logic [5:0] ctrl_r;
   logic [7:0] spare_r, duty_r, duty_nxt, fullHi_r, fullLo_r, fullLoHold_r;
   logic [6:0] bound1_r, bound2_r, hyst_r;
   logic auto_r, ramp_r, ramp_nxt;
   logic [15:0] cnt_r;
   logic [7:0] cntLoHold_r;
   logic [24:0] tick_r;
   logic tick;
   ftdm_pkg::ftdm_sec_t sec_r, sec_nxt;
   ftdm_pkg::ftdm_apb_rsp_t rsp_r;
   logic [7:0] temp, expDuty, idx;
   logic setup, done, wrDone, rdDone, hit, upEdge, dnEdge;
   logic [7:0] rdData;

   assign setup = apbReq.psel && !apbReq.penable;
   assign done = apbReq.psel && apbReq.penable && rsp_r.pready;
   assign wrDone = done && apbReq.pwrite && !rsp_r.pslverr;
   assign rdDone = done && !apbReq.pwrite && !rsp_r.pslverr;
   assign idx = apbReq.paddr[9:2];
   assign apbRsp = rsp_r;
   assign fanDuty = duty_r;
   assign section = sec_r;

   // followed temperature
   always_comb
   begin
      unique case (ctrl_r[1:0])
         2'h1: temp = temps.t1;
         2'h2: temp = temps.t2;
         2'h3: temp = temps.t3;
         default: temp = 8'h00;
      endcase
   end

   // section walk with hysteresis
   always_comb
   begin
      sec_nxt = sec_r;
      if (ctrl_r[1:0] != 2'h0)
      begin
         unique case (sec_r)
            ftdm_pkg::SEC_FULL:
               if (temp < lowEdge(bound1_r, hyst_r))
               begin
                  sec_nxt = ftdm_pkg::SEC_A;
               end
            ftdm_pkg::SEC_A:
               if (temp > {1'b0, bound1_r})
               begin
                  sec_nxt = ftdm_pkg::SEC_FULL;
               end
               else if (temp < lowEdge(bound2_r, hyst_r))
               begin
                  sec_nxt = ftdm_pkg::SEC_B;
               end
            ftdm_pkg::SEC_B:
               if (temp > {1'b0, bound1_r})
               begin
                  sec_nxt = ftdm_pkg::SEC_FULL;
               end
               else if (temp > {1'b0, bound2_r})
               begin
                  sec_nxt = ftdm_pkg::SEC_A;
               end
            default: sec_nxt = ftdm_pkg::SEC_A;
         endcase
      end
   end
   // otherwise the section holds

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         sec_r <= ftdm_pkg::SEC_A;
      end
      else
      begin
         sec_r <= sec_nxt;
      end
   end

   // expected duty of the current section
   always_comb
   begin
      unique case (sec_r)
         ftdm_pkg::SEC_FULL: expDuty = `FTDM_DUTY_FULL;
         ftdm_pkg::SEC_B: expDuty = f2SegB_r;
         default:
            if (ctrl_r[`FTDM_BIT_INTERP] && temp > {1'b0, bound2_r})
            begin
               expDuty = interp(f2SegB_r, f2SegA_r, temp - {1'b0, bound2_r},
                                {1'b0, bound1_r} - {1'b0, bound2_r});
            end
            else
            begin
               expDuty = f2SegA_r;
            end
      endcase
      if (ctrl_r[`FTDM_BIT_FORCE] && overTemp)
      begin
         expDuty = `FTDM_DUTY_FULL;
      end
   end

   // slope timebase
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         tick_r <= 25'h0000000;
      end
      else if (tick)
      begin
         tick_r <= 25'h0000000;
      end
      else
      begin
         tick_r <= tick_r + 25'h0000001;
      end
   end
   assign tick = (tick_r == 25'(SLOPE_CYCLES - 1));

   assign upEdge = (sec_r != ftdm_pkg::SEC_FULL) && (sec_nxt == ftdm_pkg::SEC_FULL);
   assign dnEdge = (sec_r == ftdm_pkg::SEC_FULL) && (sec_nxt != ftdm_pkg::SEC_FULL);

   // jump or ramp choice
   always_comb
   begin
      ramp_nxt = ramp_r;
      if (upEdge)
      begin
         ramp_nxt = !ctrl_r[`FTDM_BIT_JUMP_UP];
      end
      else if (dnEdge)
      begin
         ramp_nxt = !ctrl_r[`FTDM_BIT_JUMP_DN];
      end
      else if (ramp_r && duty_r == expDuty)
      begin
         ramp_nxt = 1'b0;
      end
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         ramp_r <= 1'b0;
      end
      else
      begin
         ramp_r <= ramp_nxt;
      end
   end

   // duty register: hardware in auto mode, software otherwise
   always_comb
   begin
      duty_nxt = duty_r;
      if (auto_r)
      begin
         if (!ramp_r)
         begin
            duty_nxt = expDuty;
         end
         else if (tick && duty_r < expDuty)
         begin
            duty_nxt = duty_r + 8'h01;
         end
         else if (tick && duty_r > expDuty)
         begin
            duty_nxt = duty_r - 8'h01;
         end
      end
      else if (wrDone && idx == `FTDM_IDX_DUTY)
      begin
         duty_nxt = apbReq.pwdata[7:0];
      end
   end

   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         duty_r <= `FTDM_RST_DUTY;
      end
      else
      begin
         duty_r <= duty_nxt;
      end
   end

   // live tach count and lsb latches
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         cnt_r <= `FTDM_RST_CNT;
         cntLoHold_r <= 8'(`FTDM_RST_CNT);
         fullLoHold_r <= `FTDM_RST_FULL_LO;
      end
      else
      begin
         if (tachValid)
         begin
            cnt_r <= tachCount;
         end
         if (rdDone && idx == `FTDM_IDX_CNT_HI)
         begin
            cntLoHold_r <= cnt_r[7:0];
         end
         if (rdDone && idx == `FTDM_IDX_FULL_HI)
         begin
            fullLoHold_r <= fullLo_r;
         end
      end
   end

   // software registers
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         f1SegA_r <= `FTDM_RST_SEGA;
         f1SegB_r <= `FTDM_RST_SEGB;
         f2SegA_r <= `FTDM_RST_SEGA;
         f2SegB_r <= `FTDM_RST_SEGB;
         ctrl_r <= `FTDM_RST_CTRL;
         spare_r <= `FTDM_RST_SPARE;
         fullHi_r <= `FTDM_RST_FULL_HI;
         fullLo_r <= `FTDM_RST_FULL_LO;
         bound1_r <= `FTDM_RST_BOUND1;
         bound2_r <= `FTDM_RST_BOUND2;
         hyst_r <= `FTDM_RST_HYST;
         auto_r <= `FTDM_RST_AUTO;
      end
      else if (wrDone)
      begin
         unique case (idx)
            `FTDM_IDX_F1_SEGA: f1SegA_r <= apbReq.pwdata[7:0];
            `FTDM_IDX_F1_SEGB: f1SegB_r <= apbReq.pwdata[7:0];
            `FTDM_IDX_F2_SEGA: f2SegA_r <= apbReq.pwdata[7:0];
            `FTDM_IDX_F2_SEGB: f2SegB_r <= apbReq.pwdata[7:0];
            `FTDM_IDX_F1_CTRL: ctrl_r <= apbReq.pwdata[5:0];
            `FTDM_IDX_SPARE: spare_r <= apbReq.pwdata[7:0];
            `FTDM_IDX_FULL_HI: fullHi_r <= apbReq.pwdata[7:0];
            `FTDM_IDX_FULL_LO: fullLo_r <= apbReq.pwdata[7:0];
            `FTDM_IDX_BOUND1: bound1_r <= apbReq.pwdata[6:0];
            `FTDM_IDX_BOUND2: bound2_r <= apbReq.pwdata[6:0];
            `FTDM_IDX_HYST: hyst_r <= apbReq.pwdata[6:0];
            `FTDM_IDX_MODE: auto_r <= apbReq.pwdata[`FTDM_BIT_AUTO];
            default:
            begin
            end
         endcase
      end
   end

   // read mux and decode
   always_comb
   begin
      hit = 1'b1;
      rdData = 8'h00;
      unique case (idx)
         `FTDM_IDX_F1_SEGA: rdData = f1SegA_r;
         `FTDM_IDX_F1_SEGB: rdData = f1SegB_r;
         `FTDM_IDX_F2_SEGA: rdData = f2SegA_r;
         `FTDM_IDX_F2_SEGB: rdData = f2SegB_r;
         `FTDM_IDX_F1_CTRL: rdData = {2'b00, ctrl_r};
         `FTDM_IDX_CNT_HI: rdData = cnt_r[15:8];
         `FTDM_IDX_CNT_LO: rdData = cntLoHold_r;
         `FTDM_IDX_SPARE: rdData = spare_r;
         `FTDM_IDX_DUTY: rdData = duty_r;
         `FTDM_IDX_FULL_HI: rdData = fullHi_r;
         `FTDM_IDX_FULL_LO: rdData = fullLoHold_r;
         `FTDM_IDX_BOUND1: rdData = {1'b0, bound1_r};
         `FTDM_IDX_BOUND2: rdData = {1'b0, bound2_r};
         `FTDM_IDX_HYST: rdData = {1'b0, hyst_r};
         `FTDM_IDX_MODE: rdData = {7'h00, auto_r};
         default: hit = 1'b0;
      endcase
      if (apbReq.paddr[1:0] != 2'b00)
      begin
         hit = 1'b0;
      end
   end

   // one wait-free answer, registered in the setup cycle
   always_ff @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         rsp_r <= '0;
      end
      else
      begin
         rsp_r.pready <= setup;
         rsp_r.pslverr <= setup && !hit;
         if (setup && !apbReq.pwrite && hit)
         begin
            rsp_r.prdata <= {24'h000000, rdData};
         end
         else if (setup)
         begin
            rsp_r.prdata <= 32'h00000000;
         end
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);

   sequence riseJump_s;
      upEdge && ctrl_r[`FTDM_BIT_JUMP_UP] && auto_r;
   endsequence
   sequence stayFull_s;
      sec_r == ftdm_pkg::SEC_FULL;
   endsequence

   full_duty_hot_a: assert property (auto_r && sec_r == ftdm_pkg::SEC_FULL && !ramp_r
      |=> duty_r == 8'hFF) else $error("full section without full duty");
   force_full_a: assert property (auto_r && !ramp_r && ctrl_r[5] && overTemp
      |=> duty_r == 8'hFF) else $error("force full not applied");
   jump_up_a: assert property (riseJump_s ##1 stayFull_s |=> duty_r == 8'hFF)
      else $error("jump up did not reach full");
   ramp_start_a: assert property (upEdge && !ctrl_r[3] |=> ramp_r)
      else $error("ramp not started");
   drop_ramp_a: assert property (dnEdge && !ctrl_r[2] |=> ramp_r)
      else $error("down ramp not started");
   drop_seg_a: assert property (sec_r == ftdm_pkg::SEC_FULL && ctrl_r[1:0] != 2'h0
      && temp < lowEdge(bound1_r, hyst_r) |=> sec_r == ftdm_pkg::SEC_A)
      else $error("no drop to segment A");
   seg_hold_a: assert property (sec_r == ftdm_pkg::SEC_A && temp <= {1'b0, bound1_r}
      && temp >= lowEdge(bound2_r, hyst_r) |=> $stable(sec_r))
      else $error("section moved inside band");
   sel_rsvd_a: assert property (ctrl_r[1:0] == 2'h0 |=> $stable(sec_r))
      else $error("reserved select moved section");
   cnt_latch_a: assert property (rdDone && idx == 8'hB0
      |=> cntLoHold_r == $past(cnt_r[7:0])) else $error("count lsb not latched");
   full_latch_a: assert property (rdDone && idx == 8'hB4
      |=> fullLoHold_r == $past(fullLo_r)) else $error("full lsb not latched");
   duty_read_a: assert property (setup && !apbReq.pwrite && idx == 8'hB3
      && apbReq.paddr[1:0] == 2'b00 |=> apbRsp.prdata[7:0] == $past(duty_r))
      else $error("duty readback wrong");

endmodule

`default_nettype wire

//--- verif/test_fan_temp_duty_mapper.sv
// self-checking bench for the fan duty mapper: apb register tasks and directed tests
// assumes ftdm_pkg compiled first and ftdm_regs.svh on the include path
`include "ftdm_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module test_fan_temp_duty_mapper;
   logic mclk;
   logic nrst;
   ftdm_pkg::ftdm_apb_req_t apbReq;
   ftdm_pkg::ftdm_apb_rsp_t apbRsp;
   ftdm_pkg::ftdm_temps_t temps;
   logic overTemp;
   logic [15:0] tachCount;
   logic tachValid;
   logic [7:0] fanDuty;
   logic [2:0] section;
   int failCount;
   int checked;
   logic [31:0] rdVal;
   logic rdErr;
   logic [7:0] idxTab [15];
   logic [7:0] rstTab [15];

   ftdm_mapper #(.SLOPE_CYCLES(4)) ftdm_mapper_inst (
      .mclk(mclk),
      .nrst(nrst),
      .apbReq(apbReq),
      .apbRsp(apbRsp),
      .temps(temps),
      .overTemp(overTemp),
      .tachCount(tachCount),
      .tachValid(tachValid),
      .fanDuty(fanDuty),
      .section(section)
   );

   always #4 mclk = ~mclk;

   task automatic endOfTest;
      $display("checked %0d failCount %0d", checked, failCount);
      if (failCount == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         failCount++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // one apb transfer, request held until pready is sampled high
   task automatic xfer(input logic wr, input logic [9:0] addr, input logic [7:0] wd);
      int n;
      n = 0;
      @(posedge mclk);
      apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: {24'h0, wd}};
      @(posedge mclk);
      apbReq.penable <= 1'b1;
      @(posedge mclk);
      while (apbRsp.pready !== 1'b1 && n < 50)
      begin
         @(posedge mclk);
         n++;
      end
      if (n >= 50)
      begin
         failCount++;
         endOfTest();
      end
      rdVal = apbRsp.prdata;
      rdErr = apbRsp.pslverr;
      apbReq <= '0;
   endtask

   // error flag, nonzero upper bits flag and data byte in one word
   function automatic logic [31:0] rdPack(input logic err, input logic [31:0] val);
      rdPack = {err, val[31:8] != 24'h000000, 22'h000000, val[7:0]};
   endfunction

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      xfer(1'b1, {idx, 2'b00}, d);
   endtask

   task automatic rdCheck(input logic [7:0] idx, input logic [7:0] exp);
      xfer(1'b0, {idx, 2'b00}, 8'h00);
      check($sformatf("reg %h", idx), rdPack(rdErr, rdVal), {24'h000000, exp});
   endtask

   task automatic settle;
      repeat (4) @(posedge mclk);
   endtask

   task automatic setTemps(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
      temps <= '{t1: a, t2: b, t3: c};
      settle();
   endtask

   task automatic mapCheck(input logic [2:0] sec, input logic [7:0] duty);
      check("section", {29'h0, section}, {29'h0, sec});
      check("fanDuty", {24'h0, fanDuty}, {24'h0, duty});
   endtask

   task automatic waitDuty(input logic [7:0] exp, input int lim);
      int n;
      n = 0;
      while (fanDuty !== exp && n < lim)
      begin
         @(posedge mclk);
         n++;
      end
      if (n >= lim)
      begin
         failCount++;
         endOfTest();
      end
      check("rampEnd", {24'h0, fanDuty}, {24'h0, exp});
   endtask

   initial
   begin
      mclk = 1'b0;
      nrst = 1'b0;
      apbReq = '0;
      temps = '{t1: 8'h10, t2: 8'h10, t3: 8'h10};
      overTemp = 1'b0;
      tachCount = 16'h0000;
      tachValid = 1'b0;
      failCount = 0;
      checked = 0;
      idxTab = '{`FTDM_IDX_F1_SEGA, `FTDM_IDX_F1_SEGB, `FTDM_IDX_F1_CTRL, `FTDM_IDX_CNT_HI,
         `FTDM_IDX_CNT_LO, `FTDM_IDX_SPARE, `FTDM_IDX_DUTY, `FTDM_IDX_FULL_HI,
         `FTDM_IDX_FULL_LO, `FTDM_IDX_BOUND1, `FTDM_IDX_HYST, `FTDM_IDX_MODE,
         `FTDM_IDX_BOUND2, `FTDM_IDX_F2_SEGA, `FTDM_IDX_F2_SEGB};
      rstTab = '{8'hD9, 8'h80, 8'h0D, 8'h0F, 8'hFF, 8'h00, 8'h80, 8'h03, 8'hFF, 8'h42,
         8'h04, 8'h01, 8'h1E, 8'hD9, 8'h80};
      repeat (20) @(posedge mclk);
      mapCheck(ftdm_pkg::SEC_A, 8'h01);
      nrst <= 1'b1;
      // reset values of every register except duty, which reads segment B
      for (int i = 0; i < 15; i++)
         rdCheck(idxTab[i], rstTab[i]);
      // unmapped and misaligned accesses
      xfer(1'b0, {8'hBA, 2'b00}, 8'h00);
      check("unmapped", rdPack(rdErr, rdVal), 32'h80000000);
      xfer(1'b1, {`FTDM_IDX_F2_SEGA, 2'b01}, 8'h00);
      check("misaligned", {31'h0, rdErr}, 32'h1);
      rdCheck(`FTDM_IDX_F2_SEGA, 8'hD9);
      // writable storage, read-only count, bit 7 of boundary
      wr(`FTDM_IDX_F1_SEGA, 8'h5A);
      rdCheck(`FTDM_IDX_F1_SEGA, 8'h5A);
      wr(`FTDM_IDX_F1_SEGB, 8'hA5);
      rdCheck(`FTDM_IDX_F1_SEGB, 8'hA5);
      wr(`FTDM_IDX_CNT_HI, 8'h77);
      rdCheck(`FTDM_IDX_CNT_HI, 8'h0F);
      wr(`FTDM_IDX_BOUND2, 8'h9E);
      rdCheck(`FTDM_IDX_BOUND2, 8'h1E);
      // count latch: msb read first, then lsb after the count moved
      tachCount <= 16'h1234;
      tachValid <= 1'b1;
      @(posedge mclk);
      tachValid <= 1'b0;
      rdCheck(`FTDM_IDX_CNT_HI, 8'h12);
      tachCount <= 16'h5678;
      tachValid <= 1'b1;
      @(posedge mclk);
      tachValid <= 1'b0;
      rdCheck(`FTDM_IDX_CNT_LO, 8'h34);
      wr(`FTDM_IDX_FULL_HI, 8'h0A);
      wr(`FTDM_IDX_FULL_LO, 8'h55);
      rdCheck(`FTDM_IDX_FULL_HI, 8'h0A);
      rdCheck(`FTDM_IDX_FULL_LO, 8'h55);
      wr(`FTDM_IDX_FULL_LO, 8'h66);
      rdCheck(`FTDM_IDX_FULL_LO, 8'h55);
      rdCheck(`FTDM_IDX_FULL_HI, 8'h0A);
      rdCheck(`FTDM_IDX_FULL_LO, 8'h66);
      // each select follows only its own temperature
      for (int s = 1; s < 4; s++)
      begin
         wr(`FTDM_IDX_F1_CTRL, {6'h03, s[1:0]});
         setTemps(8'h10, 8'h10, 8'h10);
         mapCheck(ftdm_pkg::SEC_B, 8'h80);
         setTemps(s == 1 ? 8'h10 : 8'h50, s == 2 ? 8'h10 : 8'h50, s == 3 ? 8'h10 : 8'h50);
         mapCheck(ftdm_pkg::SEC_B, 8'h80);
         setTemps(8'h50, 8'h50, 8'h50);
         mapCheck(ftdm_pkg::SEC_FULL, 8'hFF);
         setTemps(8'h10, 8'h10, 8'h10);
         settle();
         mapCheck(ftdm_pkg::SEC_B, 8'h80);
      end
      // threshold walk on temperature 2, edges and hysteresis band
      wr(`FTDM_IDX_F1_CTRL, 8'h0E);
      setTemps(8'h10, 8'h1E, 8'h10);
      mapCheck(ftdm_pkg::SEC_B, 8'h80);
      setTemps(8'h10, 8'h1F, 8'h10);
      mapCheck(ftdm_pkg::SEC_A, 8'hD9);
      setTemps(8'h10, 8'h1A, 8'h10);
      mapCheck(ftdm_pkg::SEC_A, 8'hD9);
      setTemps(8'h10, 8'h42, 8'h10);
      mapCheck(ftdm_pkg::SEC_A, 8'hD9);
      setTemps(8'h10, 8'h43, 8'h10);
      mapCheck(ftdm_pkg::SEC_FULL, 8'hFF);
      rdCheck(`FTDM_IDX_DUTY, 8'hFF);
      setTemps(8'h10, 8'h3E, 8'h10);
      mapCheck(ftdm_pkg::SEC_FULL, 8'hFF);
      setTemps(8'h10, 8'h3D, 8'h10);
      mapCheck(ftdm_pkg::SEC_A, 8'hD9);
      // reserved select freezes the section
      wr(`FTDM_IDX_F1_CTRL, 8'h0C);
      setTemps(8'h50, 8'h50, 8'h50);
      mapCheck(ftdm_pkg::SEC_A, 8'hD9);
      // forced full speed on over-temperature
      wr(`FTDM_IDX_F1_CTRL, 8'h2E);
      setTemps(8'h10, 8'h10, 8'h10);
      overTemp <= 1'b1;
      settle();
      check("forced", {24'h0, fanDuty}, 32'hFF);
      overTemp <= 1'b0;
      settle();
      settle();
      check("unforced", {24'h0, fanDuty}, 32'h80);
      // interpolation inside segment A
      wr(`FTDM_IDX_F1_CTRL, 8'h1E);
      setTemps(8'h10, 8'h30, 8'h10);
      settle();
      check("interp", {31'h0, fanDuty > 8'h80 && fanDuty < 8'hD9}, 32'h1);
      // ramps with both jump bits clear
      wr(`FTDM_IDX_F1_CTRL, 8'h02);
      settle();
      check("rampBase", {24'h0, fanDuty}, 32'hD9);
      setTemps(8'h10, 8'h50, 8'h10);
      check("rampUp", {31'h0, fanDuty !== 8'hFF}, 32'h1);
      waitDuty(8'hFF, 400);
      setTemps(8'h10, 8'h38, 8'h10);
      check("rampDown", {31'h0, fanDuty !== 8'hD9}, 32'h1);
      waitDuty(8'hD9, 400);
      // duty register owned by hardware in auto mode, by software otherwise
      wr(`FTDM_IDX_DUTY, 8'h11);
      rdCheck(`FTDM_IDX_DUTY, 8'hD9);
      wr(`FTDM_IDX_MODE, 8'h00);
      wr(`FTDM_IDX_DUTY, 8'h40);
      settle();
      check("manual", {24'h0, fanDuty}, 32'h40);
      rdCheck(`FTDM_IDX_DUTY, 8'h40);
      endOfTest();
   end

   initial
   begin
      repeat (20000) @(posedge mclk);
      failCount++;
      endOfTest();
   end
endmodule

`default_nettype wire
